// ### core/npc_regs.svh
// How it works
// - Two volatile protect bits sit at S0 and S7 of the protection register.
// - Protect bits 00 with hardware enable 0 ignore the pin; it stays IO2.
// - Protect bits 01 in software mode refuse writes while the pin is low.
// - Protect bits 10 lock the protection register until power returns them to 00.
// - Protect bits 11 enter one-time mode that allows the lock bit to set.
// - Hardware enable with pin low blocks every write, program and erase.
// - Hardware mode disables quad; register writable with pin high and hi bit 0.
// - One-time area is ten pages of 2112 bytes; programming only clears bits.
// - After the one-time lock bit sets, the whole one-time area is frozen.
// - Host sets one-time access enable before using the one-time area.
// - One-time access enable clears at power-up and on a reset command.
// - Register lock sets only with protect bits 11 and one-time access on.
// - With ECC on, parity is stored in spare area and results reported.
// - ECC enable powers up at 1 and survives the reset command.
// - Page 0 loads into the buffer after power-up; host loads pages before reads.
// - Buffer mode starts at a host column and stops after byte 2111.
// - Continuous mode starts at byte 0 and runs on after byte 2047.
// - Read mode powers up per ordered variant and is rewritable.
// - Hardware-protect enable sits at S1, defaults 0 and selects hardware mode.
// - Registers are reached by status read or write with a one-byte address.
`ifndef NPC_REGS_SVH
`define NPC_REGS_SVH

// Register address high nibbles.
`define NPC_ADDR_PROT 4'ha
`define NPC_ADDR_CFG 4'hb
`define NPC_ADDR_STAT 4'hc

// Protection register fields.
`define NPC_PROT_MODE_HI 0
`define NPC_PROT_HW_EN 1
`define NPC_PROT_BLK_LSB 2
`define NPC_PROT_BLK_MSB 6
`define NPC_PROT_MODE_LO 7
`define NPC_PROT_RESET 8'h7c

// Configuration register fields.
`define NPC_CFG_OTP_LOCK 7
`define NPC_CFG_OTP_EN 6
`define NPC_CFG_PROT_LOCK 5
`define NPC_CFG_ECC_EN 4
`define NPC_CFG_BUF 3

// One-time area and buffer geometry.
`define NPC_OTP_PAGES 4'ha
`define NPC_PAGE_BYTES 12'h840
`define NPC_BUF_LAST_COL 12'h83f
`define NPC_DATA_LAST_COL 12'h7ff
`define NPC_OTP_ERASED 8'hff

`endif

// ### core/npc_pkg.sv
package npc_pkg;

    // Protection method chosen by the two protect bits.
    typedef enum logic [1:0] {
        NPC_PM_OPEN,
        NPC_PM_PIN,
        NPC_PM_LOCKDOWN,
        NPC_PM_ONETIME
    } npc_pmode_e;

    typedef logic [7:0] npc_byte_t;

    // Decodes the protect bit pair into a protection method.
    function automatic npc_pmode_e npc_pmode(input logic hi, input logic lo);
        npc_pmode = npc_pmode_e'({hi, lo});
    endfunction

    // Programming may only pull bits low.
    function automatic npc_byte_t npc_otp_merge(input npc_byte_t old_b, input npc_byte_t new_b);
        npc_otp_merge = old_b & new_b;
    endfunction

endpackage

// ### core/npc_sync2.sv
`timescale 1ns/1ps
module npc_sync2 import npc_pkg::*; (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic d_in,
    output logic q_out
);
    logic meta_r;

    // Two stages; the pin idles high so reset loads ones.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b1;
            q_out <= 1'b1;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

// ### core/npc_otp_guard.sv
`timescale 1ns/1ps
`include "npc_regs.svh"
module npc_otp_guard import npc_pkg::*; (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic otp_access_en,
    input wire logic otp_locked,
    input wire logic write_block,
    input wire logic otp_prog_req,
    input wire logic [3:0] otp_page,
    input wire logic [7:0] otp_old_byte,
    input wire logic [7:0] otp_new_byte,
    output logic otp_prog_ok,
    output logic [7:0] otp_prog_byte
);
    // Only a page inside the area, with access on and no lock or pin block, may program.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            otp_prog_ok <= 1'b0;
            otp_prog_byte <= `NPC_OTP_ERASED;
        end else begin
            otp_prog_ok <= otp_prog_req && otp_access_en && !otp_locked && !write_block
                && (otp_page < `NPC_OTP_PAGES);
            otp_prog_byte <= npc_otp_merge(otp_old_byte, otp_new_byte);
        end
    end
endmodule

// ### core/npc_protect_config_regs.sv
`timescale 1ns/1ps
`include "npc_regs.svh"
module npc_protect_config_regs import npc_pkg::*; #(
    parameter logic BUF_DEFAULT = 1'b1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic wp_n_pin,
    input wire logic wel,
    input wire logic reg_wr_req,
    input wire logic reg_rd_req,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] stat_in,
    input wire logic dev_reset_cmd,
    input wire logic otp_prog_req,
    input wire logic [3:0] otp_page,
    input wire logic [7:0] otp_old_byte,
    input wire logic [7:0] otp_new_byte,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic wr_refused,
    output logic quad_enable,
    output logic wp_is_io2,
    output logic write_block,
    output logic otp_access,
    output logic ecc_enable,
    output logic ecc_spare_store,
    output logic buf_mode,
    output logic cont_next_page,
    output logic [11:0] col_last,
    output logic boot_page_load,
    output logic otp_prog_ok,
    output logic [7:0] otp_prog_byte
);
    logic wp_n_s;
    logic protect_mode_hi_r;
    logic protect_mode_lo_r;
    logic hw_protect_en_r;
    logic [4:0] blk_protect_r;
    logic otp_lock_r;
    logic otp_access_r;
    logic protection_reg_lock_r;
    logic ecc_en_r;
    logic buf_r;
    logic boot_done_r;
    logic wr_prot;
    logic wr_cfg;
    logic hw_block;
    logic prot_ok;
    logic cfg_ok;
    npc_pmode_e pmode;
    logic [7:0] write_protection_control;
    logic [7:0] device_configuration;

    // The pin arrives from the board, so it is synchronised first.
    npc_sync2 u_wp_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .d_in(wp_n_pin),
        .q_out(wp_n_s)
    );

    // Assemble the two registers for readback.
    assign write_protection_control = {protect_mode_lo_r, blk_protect_r, hw_protect_en_r,
        protect_mode_hi_r};
    assign device_configuration = {otp_lock_r, otp_access_r, protection_reg_lock_r, ecc_en_r,
        buf_r, 3'h0};

    // Write decode by address nibble.
    assign wr_prot = reg_wr_req && (reg_addr[7:4] == `NPC_ADDR_PROT);
    assign wr_cfg = reg_wr_req && (reg_addr[7:4] == `NPC_ADDR_CFG);
    assign pmode = npc_pmode(protect_mode_hi_r, protect_mode_lo_r);
    assign hw_block = hw_protect_en_r && !wp_n_s;

    // A config write needs the latch, no pin block and no reset command in that cycle.
    assign cfg_ok = wr_cfg && wel && !hw_block && !dev_reset_cmd;

    // Last column sent in each read mode; reset and run must agree, so it lives once.
    function automatic logic [11:0] end_column(input logic buffered);
        end_column = buffered ? `NPC_BUF_LAST_COL : `NPC_DATA_LAST_COL;
    endfunction

    // Acceptance of a protection write; the pin only matters in the cases that use it.
    always_comb begin
        prot_ok = wel && !hw_block && !protection_reg_lock_r;
        unique case (pmode)
            NPC_PM_OPEN: prot_ok = prot_ok;
            NPC_PM_PIN: prot_ok = prot_ok && (hw_protect_en_r || wp_n_s);
            NPC_PM_LOCKDOWN: prot_ok = 1'b0;
            NPC_PM_ONETIME: prot_ok = prot_ok;
        endcase
    end

    // Protection register; power-up returns the protect bits to 00.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            protect_mode_hi_r <= 1'b0;
            protect_mode_lo_r <= 1'b0;
            hw_protect_en_r <= 1'b0;
            blk_protect_r <= 5'(`NPC_PROT_RESET >> `NPC_PROT_BLK_LSB);
        end else if (wr_prot && prot_ok) begin
            protect_mode_hi_r <= reg_wdata[`NPC_PROT_MODE_HI];
            protect_mode_lo_r <= reg_wdata[`NPC_PROT_MODE_LO];
            hw_protect_en_r <= reg_wdata[`NPC_PROT_HW_EN];
            blk_protect_r <= reg_wdata[`NPC_PROT_BLK_MSB:`NPC_PROT_BLK_LSB];
        end
    end

    // Permanent lock bits; only a power cycle of the model clears them.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            otp_lock_r <= 1'b0;
            protection_reg_lock_r <= 1'b0;
        end else if (cfg_ok) begin
            if (reg_wdata[`NPC_CFG_OTP_LOCK] && otp_access_r) begin
                otp_lock_r <= 1'b1;
            end
            if (reg_wdata[`NPC_CFG_PROT_LOCK] && otp_access_r && pmode == NPC_PM_ONETIME) begin
                protection_reg_lock_r <= 1'b1;
            end
        end
    end

    // Access enable; a reset command beats a write in the same cycle.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            otp_access_r <= 1'b0;
        end else if (dev_reset_cmd) begin
            otp_access_r <= 1'b0;
        end else if (cfg_ok) begin
            otp_access_r <= reg_wdata[`NPC_CFG_OTP_EN];
        end
    end

    // ECC enable and read mode are untouched by the reset command.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ecc_en_r <= 1'b1;
            buf_r <= BUF_DEFAULT;
        end else if (cfg_ok) begin
            ecc_en_r <= reg_wdata[`NPC_CFG_ECC_EN];
            buf_r <= reg_wdata[`NPC_CFG_BUF];
        end
    end

    // Register read port answers one cycle after the request; unmapped reads give zero.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= reg_rd_req;
            if (reg_rd_req) begin
                unique case (reg_addr[7:4])
                    `NPC_ADDR_PROT: rd_data <= write_protection_control;
                    `NPC_ADDR_CFG: rd_data <= device_configuration;
                    `NPC_ADDR_STAT: rd_data <= stat_in;
                    default: rd_data <= 8'h00;
                endcase
            end
        end
    end

    // Refusal pulse for any protection write that did not land.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_refused <= 1'b0;
        end else begin
            wr_refused <= wr_prot && !prot_ok;
        end
    end

    // Pin and quad control; registered so every output comes from a flop.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            quad_enable <= 1'b1;
            wp_is_io2 <= 1'b1;
            write_block <= 1'b0;
        end else begin
            quad_enable <= !hw_protect_en_r;
            wp_is_io2 <= !hw_protect_en_r;
            write_block <= hw_block;
        end
    end

    // Mode outputs for the read path and the ECC engine.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            otp_access <= 1'b0;
            ecc_enable <= 1'b1;
            ecc_spare_store <= 1'b1;
            buf_mode <= BUF_DEFAULT;
            cont_next_page <= !BUF_DEFAULT;
            col_last <= end_column(BUF_DEFAULT);
        end else begin
            otp_access <= otp_access_r;
            ecc_enable <= ecc_en_r;
            ecc_spare_store <= ecc_en_r && !hw_block;
            buf_mode <= buf_r;
            cont_next_page <= !buf_r;
            col_last <= end_column(buf_r);
        end
    end

    // One pulse after power-up asks the array to load page 0.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_done_r <= 1'b0;
            boot_page_load <= 1'b0;
        end else begin
            boot_done_r <= 1'b1;
            boot_page_load <= !boot_done_r;
        end
    end

    // Guard for the one-time area; a lock or pin block refuses programming.
    npc_otp_guard u_otp_guard (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .otp_access_en(otp_access_r),
        .otp_locked(otp_lock_r),
        .write_block(hw_block),
        .otp_prog_req(otp_prog_req),
        .otp_page(otp_page),
        .otp_old_byte(otp_old_byte),
        .otp_new_byte(otp_new_byte),
        .otp_prog_ok(otp_prog_ok),
        .otp_prog_byte(otp_prog_byte)
    );

    // Register bus checks.
    a_read_latency: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_req |=> rd_valid) else $error("read answer missing");
    a_blocked_cfg: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_cfg && hw_block && !dev_reset_cmd) |=> $stable(device_configuration))
        else $error("blocked config write landed");
    a_reset_cmd_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        dev_reset_cmd |=> (!otp_access_r && $stable(ecc_en_r)))
        else $error("reset command effect wrong");
    a_reset_cmd_buf: assert property (@(posedge core_clk) disable iff (!reset_n)
        dev_reset_cmd |=> $stable(buf_r)) else $error("reset command moved read mode");

    // Protection register checks; a refused write must leave no trace.
    a_lockdown_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_prot && pmode == NPC_PM_LOCKDOWN) |=> ($stable(write_protection_control)
        && wr_refused)) else $error("lockdown write landed");
    a_pin_refuse: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_prot && pmode == NPC_PM_PIN && !hw_protect_en_r && !wp_n_s) |=> wr_refused)
        else $error("pin low write accepted");
    a_pin_accept: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_prot && pmode == NPC_PM_PIN && wp_n_s && wel && !hw_block && !protection_reg_lock_r)
        |=> !wr_refused) else $error("pin high write refused");
    a_refuse_no_side: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_prot && !prot_ok) |=> $stable(write_protection_control))
        else $error("refused write changed register");
    a_accept_no_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_prot && prot_ok) |=> !wr_refused) else $error("accepted write flagged refused");
    a_reglock_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(protection_reg_lock_r) |-> ($past(pmode) == NPC_PM_ONETIME
        && $past(otp_access_r))) else $error("lock set outside one-time mode");
    a_reglock_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
        protection_reg_lock_r |=> protection_reg_lock_r) else $error("register lock dropped");
    a_reglock_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
        protection_reg_lock_r |=> $stable(write_protection_control))
        else $error("locked register changed");

    // Pin and quad checks; the pin is only ever seen through the synchroniser.
    a_hw_block: assert property (@(posedge core_clk) disable iff (!reset_n)
        (hw_protect_en_r && !wp_n_s) |=> write_block) else $error("pin block missing");
    a_spare_block: assert property (@(posedge core_clk) disable iff (!reset_n)
        hw_block |=> !ecc_spare_store) else $error("spare store during pin block");
    a_quad_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        hw_protect_en_r |=> !quad_enable) else $error("quad left on");
    a_quad_soft: assert property (@(posedge core_clk) disable iff (!reset_n)
        !hw_protect_en_r |=> (quad_enable && wp_is_io2))
        else $error("io2 lost in software mode");

    // One-time area checks.
    a_otp_lock_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
        otp_lock_r |=> otp_lock_r) else $error("one-time lock dropped");
    a_otp_lock_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(otp_lock_r) |-> $past(otp_access_r))
        else $error("one-time lock set without access");
    a_otp_locked_prog: assert property (@(posedge core_clk) disable iff (!reset_n)
        otp_lock_r |=> !otp_prog_ok) else $error("locked area programmed");
    a_otp_range: assert property (@(posedge core_clk) disable iff (!reset_n)
        (otp_prog_req && otp_page >= `NPC_OTP_PAGES) |=> !otp_prog_ok)
        else $error("page outside area programmed");
    a_otp_access_need: assert property (@(posedge core_clk) disable iff (!reset_n)
        (otp_prog_req && !otp_access_r) |=> !otp_prog_ok)
        else $error("programmed without access");

    // Read mode and boot checks.
    a_col_last_buf: assert property (@(posedge core_clk) disable iff (!reset_n)
        buf_r |=> (col_last == `NPC_BUF_LAST_COL)) else $error("buffer end column wrong");
    a_cont_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
        !buf_r |=> (cont_next_page && col_last == `NPC_DATA_LAST_COL))
        else $error("continuous mode outputs wrong");
    a_boot_once: assert property (@(posedge core_clk) disable iff (!reset_n)
        boot_page_load |=> !boot_page_load) else $error("boot load longer than a cycle");

    // Main scenarios worth seeing at least once.
    c_prot_write: cover property (@(posedge core_clk) disable iff (!reset_n) wr_prot && prot_ok);
    c_reg_lock: cover property (@(posedge core_clk) disable iff (!reset_n)
        $rose(protection_reg_lock_r));
    c_hw_block: cover property (@(posedge core_clk) disable iff (!reset_n) write_block);
    c_cont_mode: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(buf_r));
    c_otp_grant: cover property (@(posedge core_clk) disable iff (!reset_n) otp_prog_ok);

endmodule

// ### tb/npc_host.sv
`timescale 1ns/1ps
// Host side of the register instruction path: one request pulse per instruction.
module npc_host (
    input wire logic core_clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic wr_refused,
    output logic reg_wr_req,
    output logic reg_rd_req,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    int gap = 0; // Idle cycles before each request, so the host can act slowly.

    initial begin
        reg_wr_req = 1'b0;
        reg_rd_req = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Called just after an edge; the request stands for exactly one sampling edge.
    task automatic issue(input logic wr, input logic [7:0] a, input logic [7:0] d);
        repeat (gap) begin
            @(posedge core_clk);
            #1;
        end
        reg_addr = a;
        reg_wdata = d;
        reg_wr_req = wr;
        reg_rd_req = !wr;
        @(posedge core_clk);
        #1;
        reg_wr_req = 1'b0;
        reg_rd_req = 1'b0;
    endtask

    // The refusal pulse may land on either of the two edges after the request.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic refused);
        issue(1'b1, a, d);
        refused = wr_refused;
        @(posedge core_clk);
        #1;
        refused = refused | wr_refused;
    endtask

    // Waits a bounded number of edges for the answer; no answer leaves unknowns.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        q = 8'hxx;
        issue(1'b0, a, 8'h00);
        for (int i = 0; i < 3; i++) begin
            if (rd_valid === 1'b1) begin
                q = rd_data;
                break;
            end
            @(posedge core_clk);
            #1;
        end
        // One idle edge, so that the next request never reuses this time step.
        @(posedge core_clk);
        #1;
    endtask
endmodule

// ### tb/npc_protect_config_regs_tb.sv
`timescale 1ns/1ps
module npc_protect_config_regs_tb;
    logic core_clk, reset_n, wp_n_pin, wel, dev_reset_cmd, otp_prog_req;
    logic reg_wr_req, reg_rd_req, rd_valid, wr_refused, quad_enable, wp_is_io2;
    logic write_block, otp_access, ecc_enable, ecc_spare_store, buf_mode;
    logic cont_next_page, boot_page_load, otp_prog_ok;
    logic [3:0] otp_page;
    logic [7:0] reg_addr, reg_wdata, stat_in, otp_old_byte, otp_new_byte;
    logic [7:0] rd_data, otp_prog_byte;
    logic [11:0] col_last;
    int failures = 0;
    int comparisons = 0;
    int boot_cnt = 0;

    npc_protect_config_regs uut (.core_clk(core_clk), .reset_n(reset_n), .wp_n_pin(wp_n_pin),
        .wel(wel), .reg_wr_req(reg_wr_req), .reg_rd_req(reg_rd_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .stat_in(stat_in), .dev_reset_cmd(dev_reset_cmd),
        .otp_prog_req(otp_prog_req), .otp_page(otp_page), .otp_old_byte(otp_old_byte),
        .otp_new_byte(otp_new_byte), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_refused(wr_refused), .quad_enable(quad_enable), .wp_is_io2(wp_is_io2),
        .write_block(write_block), .otp_access(otp_access), .ecc_enable(ecc_enable),
        .ecc_spare_store(ecc_spare_store), .buf_mode(buf_mode),
        .cont_next_page(cont_next_page), .col_last(col_last),
        .boot_page_load(boot_page_load), .otp_prog_ok(otp_prog_ok),
        .otp_prog_byte(otp_prog_byte));

    npc_host host (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_refused(wr_refused), .reg_wr_req(reg_wr_req), .reg_rd_req(reg_rd_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // Free-running 10 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Counts falling edges with the boot pulse high, away from the edge that launches it.
    always @(negedge core_clk) begin
        if (boot_page_load === 1'b1) boot_cnt++;
    end

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d, input logic exp_ref);
        logic r;
        host.wr(a, d, r);
        chk("write refusal", {11'h000, exp_ref}, {11'h000, r});
    endtask

    task automatic r(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.rd(a, q);
        chk("read data", {4'h0, exp}, {4'h0, q});
    endtask

    // Derived outputs trail their register by a cycle; two edges cover it.
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // The pin passes a two-flop synchroniser before it takes effect.
    task automatic pin(input logic v);
        wp_n_pin = v;
        settle(4);
    endtask

    task automatic otp(input logic [3:0] pg, input logic [7:0] nb, input logic exp_ok);
        logic ok;
        otp_page = pg;
        otp_old_byte = 8'hf0;
        otp_new_byte = nb;
        otp_prog_req = 1'b1;
        settle(1);
        otp_prog_req = 1'b0;
        ok = otp_prog_ok;
        settle(1);
        ok = ok | otp_prog_ok;
        chk("otp grant", {11'h000, exp_ok}, {11'h000, ok});
        chk("otp byte", {4'h0, 8'hf0 & nb}, {4'h0, otp_prog_byte});
    endtask

    task automatic power_cycle();
        reset_n = 1'b0;
        settle(2);
        reset_n = 1'b1;
    endtask

    task automatic close_out();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang is cut short well past the 140 or so cycles the tests need.
    initial begin
        #(3000 * 100);
        failures++;
        close_out();
    end

    initial begin
        {reset_n, dev_reset_cmd, otp_prog_req, otp_page} = 7'h00;
        {wp_n_pin, wel, stat_in} = 10'h35a;
        {otp_old_byte, otp_new_byte} = 16'h0000;
        settle(8);
        reset_n = 1'b1;
        r(8'ha0, 8'h7c);
        r(8'hb0, 8'h18);
        r(8'hc5, 8'h5a);
        chk("quad and io2", 12'h003, {10'h000, quad_enable, wp_is_io2});
        chk("last column", 12'h83f, col_last);
        $display("test reset values done");
        pin(1'b0);
        w(8'ha0, 8'h04, 1'b0);
        w(8'ha0, 8'h80, 1'b0);
        w(8'ha0, 8'h84, 1'b1);
        r(8'ha0, 8'h80);
        chk("io2 in pin mode", 12'h001, {11'h000, wp_is_io2});
        pin(1'b1);
        w(8'ha0, 8'h88, 1'b0);
        wel = 1'b0;
        w(8'ha0, 8'h00, 1'b1);
        wel = 1'b1;
        r(8'ha0, 8'h88);
        $display("test software protection done");
        host.gap = 2;
        w(8'ha0, 8'h02, 1'b0);
        settle(2);
        chk("quad and io2", 12'h000, {10'h000, quad_enable, wp_is_io2});
        pin(1'b0);
        chk("write block", 12'h001, {11'h000, write_block});
        w(8'ha0, 8'h00, 1'b1);
        w(8'hb0, 8'h08, 1'b0);
        r(8'hb0, 8'h18);
        pin(1'b1);
        w(8'ha0, 8'h00, 1'b0);
        r(8'ha0, 8'h00);
        host.gap = 0;
        $display("test hardware protection done");
        w(8'hb0, 8'h10, 1'b0);
        settle(2);
        chk("read mode", 12'h001, {10'h000, buf_mode, cont_next_page});
        chk("last column", 12'h7ff, col_last);
        w(8'hb0, 8'h18, 1'b0);
        settle(2);
        chk("read mode", 12'h002, {10'h000, buf_mode, cont_next_page});
        chk("last column", 12'h83f, col_last);
        $display("test read modes done");
        w(8'hb0, 8'h48, 1'b0);
        r(8'hb0, 8'h48);
        settle(2);
        chk("ecc and access", 12'h001, {9'h000, ecc_enable, ecc_spare_store, otp_access});
        dev_reset_cmd = 1'b1;
        settle(1);
        dev_reset_cmd = 1'b0;
        settle(2);
        r(8'hb0, 8'h08);
        $display("test reset command done");
        w(8'hb0, 8'h18, 1'b0);
        otp(4'h9, 8'h3c, 1'b0);
        w(8'hb0, 8'h58, 1'b0);
        settle(2);
        otp(4'h9, 8'h3c, 1'b1);
        otp(4'ha, 8'h3c, 1'b0);
        w(8'hb0, 8'h78, 1'b0);
        r(8'hb0, 8'h58);
        w(8'ha0, 8'h81, 1'b0);
        w(8'hb0, 8'h78, 1'b0);
        r(8'hb0, 8'h78);
        w(8'ha0, 8'h7c, 1'b1);
        r(8'ha0, 8'h81);
        w(8'hb0, 8'hf8, 1'b0);
        r(8'hb0, 8'hf8);
        settle(2);
        otp(4'h0, 8'h00, 1'b0);
        $display("test one-time area and locks done");
        power_cycle();
        r(8'hb0, 8'h18);
        w(8'ha0, 8'h01, 1'b0);
        w(8'ha0, 8'h00, 1'b1);
        r(8'ha0, 8'h01);
        power_cycle();
        r(8'ha0, 8'h7c);
        chk("boot loads", 12'h003, boot_cnt[11:0]);
        $display("test power lock-down done");
        close_out();
    end
endmodule
